// file: hw/tsr_pkg.sv
// Purpose: Shared constants and types of the tape status reporting block
// Assumes: Classic Wishbone register access, 32-bit data
// Notes: Status bit positions follow the status word layout

package tsr_pkg;

    // --------
    // Register byte offsets
    // --------
    localparam logic [7:0] TSR_OFF_FUNC = 8'h00;
    localparam logic [7:0] TSR_OFF_STATUS = 8'h04;
    localparam logic [7:0] TSR_OFF_CTRL = 8'h08;
    localparam logic [7:0] TSR_OFF_DATA = 8'h0c;

    // --------
    // Function word fields
    // --------
    localparam int TSR_FW_UNIT_LSB = 0;
    localparam int TSR_FW_NINE = 3;
    localparam int TSR_FW_ILLEGAL = 4;
    localparam int TSR_FW_CODE_LSB = 5;
    localparam int TSR_FW_SKIP_ONLY = 8;
    localparam int TSR_FW_WIDTH = 9;

    // Function codes
    localparam logic [2:0] TSR_FN_WEOF = 3'h0;
    localparam logic [2:0] TSR_FN_RDBACK = 3'h1;
    localparam logic [2:0] TSR_FN_REW_IL = 3'h2;
    localparam logic [2:0] TSR_FN_REW_LP = 3'h3;
    localparam logic [2:0] TSR_FN_BOOT = 3'h4;
    localparam logic [2:0] TSR_FN_WRITE = 3'h5;
    localparam logic [2:0] TSR_FN_RDFWD = 3'h6;
    localparam logic [2:0] TSR_FN_SKIP = 3'h7;

    // --------
    // Status word bit positions
    // --------
    localparam int TSR_SW_WIDTH = 18;
    localparam int TSR_SB_INVALID = 9;
    localparam int TSR_SB_HASH = 10;
    localparam int TSR_SB_LATE = 11;
    localparam int TSR_SB_PARITY = 12;
    localparam int TSR_SB_BUSY = 13;
    localparam int TSR_SB_INTERLOCK = 14;
    localparam int TSR_SB_EOT_LP = 15;

    // Control register fields and reset values
    localparam int TSR_CB_AUX = 0;
    localparam int TSR_CB_SEL_NINE = 1;
    localparam int TSR_CB_RUNNING = 8;
    localparam int TSR_CB_DONE = 9;
    localparam logic TSR_AUX_RST = 1'b0;
    localparam logic TSR_SEL_NINE_RST = 1'b1;

    // End-of-file frame pattern
    localparam logic [8:0] TSR_EOF_FRAME = 9'h013;

    // Tape motion commands
    localparam logic [1:0] TSR_MOT_STOP = 2'h0;
    localparam logic [1:0] TSR_MOT_FWD = 2'h1;
    localparam logic [1:0] TSR_MOT_BWD = 2'h2;
    localparam logic [1:0] TSR_MOT_REW = 2'h3;

    // --------
    // Timing
    // --------
    localparam int TSR_CLK_PERIOD_NS = 4;
    localparam int TSR_LATE_DELAY_NS = 29000;
    localparam int TSR_LATE_DELAY_CYC =
        (TSR_LATE_DELAY_NS + TSR_CLK_PERIOD_NS - 1) / TSR_CLK_PERIOD_NS;
    localparam int TSR_TIMER_W = 16;

    // Units
    localparam int TSR_UNITS = 8;

    typedef struct packed {
        logic [TSR_UNITS-1:0] nine_track;
        logic [TSR_UNITS-1:0] rewinding;
        logic [TSR_UNITS-1:0] other_cu;
        logic [TSR_UNITS-1:0] interlock;
        logic [TSR_UNITS-1:0] powered;
        logic [TSR_UNITS-1:0] eot;
        logic [TSR_UNITS-1:0] load_point;
        logic hash;
        logic lat_par;
        logic lon_par;
        logic frame_done;
        logic op_done;
    } tsr_tape_in_s;

    localparam int TSR_TAPE_IN_W = $bits(tsr_tape_in_s);

    typedef enum logic [4:0] {
        TSR_ST_IDLE = 5'b0_0001,
        TSR_ST_CHECK = 5'b0_0010,
        TSR_ST_RUN = 5'b0_0100,
        TSR_ST_POST = 5'b0_1000,
        TSR_ST_FINISH = 5'b1_0000
    } tsr_state_e;

endpackage : tsr_pkg

// file: hw/tsr_sync.sv
// Purpose: Two-stage synchroniser for the tape unit lines
// Assumes: Inputs are asynchronous levels
// Notes: First stage is read by the second stage only

`timescale 1ns/1ns

module tsr_sync
    import tsr_pkg::*;
#(
    parameter int WIDTH = TSR_TAPE_IN_W
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } tsr_sync_s;

    tsr_sync_s sync_reg;
    tsr_sync_s sync_next;

    if (WIDTH < 1)
    begin : g_chk
        $error("tsr_sync: WIDTH must be positive");
    end

    always_comb
    begin
        sync_next.meta = async_i;
        sync_next.stable = sync_reg.meta;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_reg <= '0;
        end
        else
        begin
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg.stable;

endmodule : tsr_sync

// file: hw/tsr_ctrl.sv
// Purpose: Tape control unit status word generation and error reporting
// Assumes: Wishbone classic slave, tape unit lines asynchronous
// Notes: One function in flight; status valid until the next function or a write-one-to-clear of done
//
// Functional notes
// - Tape hash set when data sensed in blank area on write-type functions
// - Invalid function is the only bit set and tape never moves
// - Auxiliary unit rejects write end-of-file, write, skip functions
// - Function word with bit 4 set is invalid
// - Track format mismatch with addressed unit is invalid, except on rewind and bootstrap
// - Bootstrap invalid when selector switch mismatches unit zero type
// - Interlock reported alone and without tape motion
// - Busy alone leaves the addressed unit untouched
// - Busy reported while the addressed unit still rewinds
// - Busy reported when the other control unit holds the unit
// - Busy plus end-of-tape on power drop outside rewinds; also load point on read back
// - Parity error on lateral or longitudinal error of end-of-file frame
// - End-of-tape warning without busy after write end-of-file
// - Standard unit flags late data word after delay until status
// - Write end-of-file records a block of one frame
// - End-of-file frame carries fixed pattern 000010011

`timescale 1ns/1ns

module tsr_ctrl
    import tsr_pkg::*;
#(
    parameter int LATE_DELAY_CYCLES = TSR_LATE_DELAY_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire tsr_tape_in_s tape_i,
    output logic [2:0] tape_unit_o,
    output logic [1:0] tape_move_o,
    output logic [8:0] frame_data_o,
    output logic frame_stb_o,
    output logic [31:0] data_word_o,
    output logic data_stb_o,
    output logic [TSR_SW_WIDTH-1:0] status_o,
    output logic status_valid_o
);

    // --------
    // Elaboration checks
    // --------
    if (LATE_DELAY_CYCLES < 1 || LATE_DELAY_CYCLES >= (1 << TSR_TIMER_W))
    begin : g_chk
        $error("tsr_ctrl: LATE_DELAY_CYCLES out of range");
    end

    localparam logic [TSR_TIMER_W-1:0] LATE_LOAD =
        TSR_TIMER_W'(LATE_DELAY_CYCLES);

    // --------
    // State
    // --------
    typedef struct packed {
        tsr_state_e state;
        logic [TSR_FW_WIDTH-1:0] func;
        logic [TSR_SW_WIDTH-1:0] status;
        logic aux;
        logic sel_nine;
        logic done;
        logic late_open;
        logic [TSR_TIMER_W-1:0] timer;
        logic ack;
        logic [31:0] rdata;
        logic [2:0] unit;
        logic [1:0] move;
        logic [8:0] frame;
        logic fstb;
        logic [31:0] dword;
        logic dstb;
    } tsr_ctrl_s;

    tsr_ctrl_s ctrl_reg;
    tsr_ctrl_s ctrl_next;
    tsr_tape_in_s tin;

    // --------
    // Input synchronisation
    // --------
    tsr_sync #(
        .WIDTH(TSR_TAPE_IN_W)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(tape_i),
        .sync_o(tin)
    );

    // --------
    // Helpers
    // --------
    function automatic logic is_write_class(input logic [2:0] code);
        is_write_class = (code == TSR_FN_WEOF) || (code == TSR_FN_WRITE) ||
                         (code == TSR_FN_SKIP);
    endfunction : is_write_class

    function automatic logic is_rewind(input logic [2:0] code);
        is_rewind = (code == TSR_FN_REW_IL) || (code == TSR_FN_REW_LP);
    endfunction : is_rewind

    function automatic logic [TSR_SW_WIDTH-1:0] sbit(input int pos);
        sbit = TSR_SW_WIDTH'(1) << pos;
    endfunction : sbit

    function automatic logic [1:0] motion_of(input logic [2:0] code);
        case (code)
            TSR_FN_RDBACK: motion_of = TSR_MOT_BWD;
            TSR_FN_REW_IL: motion_of = TSR_MOT_REW;
            TSR_FN_REW_LP: motion_of = TSR_MOT_REW;
            default: motion_of = TSR_MOT_FWD;
        endcase
    endfunction : motion_of

    // --------
    // Next state
    // --------
    logic bus_req;
    logic bus_wr;
    logic [2:0] fw_unit;
    logic [2:0] fw_code;
    logic fw_nine;
    logic invalid;

    always_comb
    begin
        ctrl_next = ctrl_reg;
        bus_req = wb_cyc_i && wb_stb_i && !ctrl_reg.ack;
        bus_wr = bus_req && wb_we_i;
        fw_unit = ctrl_reg.func[TSR_FW_UNIT_LSB +: 3];
        fw_code = ctrl_reg.func[TSR_FW_CODE_LSB +: 3];
        fw_nine = ctrl_reg.func[TSR_FW_NINE];
        invalid = 1'b0;

        ctrl_next.ack = bus_req;
        ctrl_next.rdata = '0;
        ctrl_next.fstb = 1'b0;
        ctrl_next.dstb = 1'b0;

        // Register reads; unmapped offsets answer with zero
        if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                TSR_OFF_FUNC: ctrl_next.rdata = 32'(ctrl_reg.func);
                TSR_OFF_STATUS: ctrl_next.rdata = 32'(ctrl_reg.status);
                TSR_OFF_CTRL:
                begin
                    ctrl_next.rdata[TSR_CB_AUX] = ctrl_reg.aux;
                    ctrl_next.rdata[TSR_CB_SEL_NINE] = ctrl_reg.sel_nine;
                    ctrl_next.rdata[TSR_CB_RUNNING] =
                        (ctrl_reg.state != TSR_ST_IDLE);
                    ctrl_next.rdata[TSR_CB_DONE] = ctrl_reg.done;
                end
                TSR_OFF_DATA: ctrl_next.rdata = ctrl_reg.dword;
                default: ctrl_next.rdata = '0;
            endcase
        end

        // Control writes; done is write-one-to-clear
        if (bus_wr && wb_adr_i == TSR_OFF_CTRL && wb_sel_i[0])
        begin
            ctrl_next.aux = wb_dat_i[TSR_CB_AUX];
            ctrl_next.sel_nine = wb_dat_i[TSR_CB_SEL_NINE];
        end
        if (bus_wr && wb_adr_i == TSR_OFF_CTRL && wb_sel_i[1] &&
            wb_dat_i[TSR_CB_DONE])
        begin
            ctrl_next.done = 1'b0;
        end

        // Output data words; late arrivals flagged on the standard unit
        if (bus_wr && wb_adr_i == TSR_OFF_DATA)
        begin
            ctrl_next.dword = wb_dat_i;
            ctrl_next.dstb = 1'b1;
            if (ctrl_reg.late_open && !ctrl_reg.aux)
            begin
                ctrl_next.status[TSR_SB_LATE] = 1'b1;
            end
        end

        case (ctrl_reg.state)
            TSR_ST_IDLE:
            begin
                // New functions only accepted while idle
                if (bus_wr && wb_adr_i == TSR_OFF_FUNC)
                begin
                    ctrl_next.func = wb_dat_i[TSR_FW_WIDTH-1:0];
                    ctrl_next.done = 1'b0;
                    ctrl_next.state = TSR_ST_CHECK;
                end
            end
            TSR_ST_CHECK:
            begin
                if (ctrl_reg.func[TSR_FW_ILLEGAL])
                begin
                    invalid = 1'b1;
                end
                if (ctrl_reg.aux && is_write_class(fw_code))
                begin
                    invalid = 1'b1;
                end
                if (fw_code == TSR_FN_BOOT)
                begin
                    if (ctrl_reg.sel_nine != tin.nine_track[0])
                    begin
                        invalid = 1'b1;
                    end
                end
                else if (!is_rewind(fw_code) &&
                         fw_nine != tin.nine_track[fw_unit])
                begin
                    invalid = 1'b1;
                end

                ctrl_next.status = '0;
                ctrl_next.state = TSR_ST_FINISH;
                if (invalid)
                begin
                    ctrl_next.status = sbit(TSR_SB_INVALID);
                end
                else if (tin.interlock[fw_unit])
                begin
                    ctrl_next.status = sbit(TSR_SB_INTERLOCK);
                end
                else if (tin.rewinding[fw_unit] || tin.other_cu[fw_unit])
                begin
                    // Unit select and motion stay as they were
                    ctrl_next.status = sbit(TSR_SB_BUSY);
                end
                else
                begin
                    ctrl_next.unit = fw_unit;
                    ctrl_next.move = motion_of(fw_code);
                    ctrl_next.state = TSR_ST_RUN;
                    if (fw_code == TSR_FN_WEOF)
                    begin
                        ctrl_next.frame = TSR_EOF_FRAME;
                        ctrl_next.fstb = 1'b1;
                    end
                end
            end
            TSR_ST_RUN, TSR_ST_POST:
            begin
                if (!tin.powered[ctrl_reg.unit] && !is_rewind(fw_code))
                begin
                    // Abort: power lost mid-function
                    ctrl_next.status = sbit(TSR_SB_BUSY) |
                                       sbit(TSR_SB_EOT_LP);
                    ctrl_next.state = TSR_ST_FINISH;
                end
                else if (fw_code == TSR_FN_RDBACK &&
                         tin.load_point[ctrl_reg.unit])
                begin
                    ctrl_next.status = sbit(TSR_SB_BUSY) |
                                       sbit(TSR_SB_EOT_LP);
                    ctrl_next.state = TSR_ST_FINISH;
                end
                else
                begin
                    if (tin.hash && is_write_class(fw_code))
                    begin
                        ctrl_next.status[TSR_SB_HASH] = 1'b1;
                    end
                    if (fw_code == TSR_FN_WEOF &&
                        (tin.lat_par || tin.lon_par))
                    begin
                        ctrl_next.status[TSR_SB_PARITY] = 1'b1;
                    end
                    if (ctrl_reg.state == TSR_ST_RUN &&
                        fw_code == TSR_FN_WEOF && tin.frame_done)
                    begin
                        ctrl_next.timer = LATE_LOAD;
                        ctrl_next.state = TSR_ST_POST;
                    end
                    else if (ctrl_reg.state == TSR_ST_POST &&
                             ctrl_reg.timer != '0)
                    begin
                        ctrl_next.timer = ctrl_reg.timer - 1'b1;
                        if (ctrl_reg.timer == TSR_TIMER_W'(1))
                        begin
                            ctrl_next.late_open = 1'b1;
                        end
                    end
                    if (tin.op_done && (fw_code != TSR_FN_WEOF ||
                                        ctrl_reg.state == TSR_ST_POST))
                    begin
                        if (fw_code == TSR_FN_WEOF &&
                            tin.eot[ctrl_reg.unit])
                        begin
                            ctrl_next.status[TSR_SB_EOT_LP] = 1'b1;
                        end
                        ctrl_next.state = TSR_ST_FINISH;
                    end
                end
            end
            TSR_ST_FINISH:
            begin
                // Status word generated: window closes, motion stops
                ctrl_next.late_open = 1'b0;
                ctrl_next.timer = '0;
                ctrl_next.move = TSR_MOT_STOP;
                ctrl_next.done = 1'b1;
                ctrl_next.state = TSR_ST_IDLE;
            end
            default:
            begin
                ctrl_next.state = TSR_ST_IDLE;
            end
        endcase
    end

    // --------
    // Registers
    // --------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl_reg <= '0;
            ctrl_reg.state <= TSR_ST_IDLE;
            ctrl_reg.aux <= TSR_AUX_RST;
            ctrl_reg.sel_nine <= TSR_SEL_NINE_RST;
            ctrl_reg.move <= TSR_MOT_STOP;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
        end
    end

    // --------
    // Outputs
    // --------
    assign wb_dat_o = ctrl_reg.rdata;
    assign wb_ack_o = ctrl_reg.ack;
    assign tape_unit_o = ctrl_reg.unit;
    assign tape_move_o = ctrl_reg.move;
    assign frame_data_o = ctrl_reg.frame;
    assign frame_stb_o = ctrl_reg.fstb;
    assign data_word_o = ctrl_reg.dword;
    assign data_stb_o = ctrl_reg.dstb;
    assign status_o = ctrl_reg.status;
    assign status_valid_o = ctrl_reg.done;

endmodule : tsr_ctrl

// file: sim/tsr_tape_model.sv
// Purpose: Tape unit responder for the status block bench
// Assumes: One function at a time, levels held by the bench
// Notes: Done levels drop once motion stops, so none leak
`timescale 1ns/1ns

module tsr_tape_model
    import tsr_pkg::*;
(
    input wire logic clk_i,
    input wire logic [1:0] move_i,
    input wire logic frame_stb_i,
    input wire logic drop_i,
    input wire logic [7:0] op_len_i,
    input wire tsr_tape_in_s cond_i,
    output tsr_tape_in_s tape_o
);
    int run_cnt = 0;
    int frm_cnt = 0;
    logic moving;

    assign moving = move_i != TSR_MOT_STOP;

    always @(posedge clk_i)
    begin
        run_cnt <= moving ? run_cnt + 1 : 0;
        frm_cnt <= frame_stb_i ? 1 : (moving ? frm_cnt + 1 : 0);
    end

    always_comb
    begin
        tape_o = cond_i;
        tape_o.frame_done = moving && frm_cnt > 3;
        tape_o.op_done = moving && run_cnt > int'(op_len_i);
        // Power loss only while the unit is in motion
        if (drop_i && moving)
            tape_o.powered = 8'h00;
    end
endmodule : tsr_tape_model

// file: sim/tsr_ctrl_props.sv
// Purpose: Port checks of the tape status block
// Assumes: One clock, synchronous reset
// Notes: Motion flags clear at each function write
`timescale 1ns/1ns

module tsr_ctrl_props
    import tsr_pkg::*;
#(
    parameter int LATE_DELAY_CYCLES = TSR_LATE_DELAY_CYC
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic [2:0] tape_unit_o,
    input wire logic [1:0] tape_move_o,
    input wire logic [8:0] frame_data_o,
    input wire logic frame_stb_o,
    input wire logic [TSR_SW_WIDTH-1:0] status_o,
    input wire logic status_valid_o
);
    localparam logic [17:0] INV = 18'h0_0001 << TSR_SB_INVALID;
    localparam logic [17:0] ILK = 18'h0_0001 << TSR_SB_INTERLOCK;
    localparam logic [17:0] BSY = 18'h0_0001 << TSR_SB_BUSY;
    logic fn_wr;
    logic moved_reg;
    logic unit_chg_reg;

    // --------
    // Helper flags
    // --------
    assign fn_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == TSR_OFF_FUNC;

    always_ff @(posedge clk_i)
    begin
        if (rst_i || fn_wr)
        begin
            moved_reg <= 1'b0;
            unit_chg_reg <= 1'b0;
        end
        else
        begin
            moved_reg <= moved_reg || tape_move_o != TSR_MOT_STOP;
            unit_chg_reg <= unit_chg_reg || $changed(tape_unit_o);
        end
    end

    // --------
    // Assertions
    // --------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    chk_inv_alone: assert property (
        status_valid_o && status_o[TSR_SB_INVALID]
        |-> status_o == INV && !moved_reg)
        else $error("invalid not alone");
    chk_ilk_alone: assert property (
        status_valid_o && status_o[TSR_SB_INTERLOCK]
        |-> status_o == ILK && !moved_reg)
        else $error("interlock not alone");
    chk_busy_still: assert property (
        status_valid_o && status_o == BSY
        |-> !moved_reg && !unit_chg_reg)
        else $error("busy unit touched");
    chk_bit4_inv: assert property (
        fn_wr && wb_dat_i[TSR_FW_ILLEGAL]
        |-> ##[3:5] status_valid_o && status_o == INV)
        else $error("bit 4 not invalid");
    chk_eof_pattern: assert property (
        frame_stb_o |-> frame_data_o == TSR_EOF_FRAME)
        else $error("frame pattern wrong");
    chk_one_frame: assert property (
        frame_stb_o |=> (!frame_stb_o) [*8])
        else $error("extra frame");
    chk_frame_fwd: assert property (
        frame_stb_o |-> tape_move_o == TSR_MOT_FWD)
        else $error("frame without motion");
    chk_hash_moved: assert property (
        status_valid_o && status_o[TSR_SB_HASH] |-> moved_reg)
        else $error("hash without motion");
    chk_free_bits: assert property (
        status_o[8:0] == 9'h000 && status_o[17:16] == 2'h0)
        else $error("unused status bits set");
endmodule : tsr_ctrl_props

bind tsr_ctrl tsr_ctrl_props #(.LATE_DELAY_CYCLES(LATE_DELAY_CYCLES)) u_props
(
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_ack_o(wb_ack_o), .tape_unit_o(tape_unit_o),
    .tape_move_o(tape_move_o), .frame_data_o(frame_data_o),
    .frame_stb_o(frame_stb_o), .status_o(status_o),
    .status_valid_o(status_valid_o)
);

// file: sim/tb_tape_status_error_reporting.sv
// Purpose: Self-checking bench of the tape status block
// Assumes: Tape model answers every motion
// Notes: Late delay cut to 20 cycles to keep runs short
`timescale 1ns/1ns

module tb_tape_status_error_reporting;
    import tsr_pkg::*;
    localparam logic [17:0] INV = 18'h0_0001 << TSR_SB_INVALID;
    localparam logic [17:0] HSH = 18'h0_0001 << TSR_SB_HASH;
    localparam logic [17:0] LAT = 18'h0_0001 << TSR_SB_LATE;
    localparam logic [17:0] PAR = 18'h0_0001 << TSR_SB_PARITY;
    localparam logic [17:0] BSY = 18'h0_0001 << TSR_SB_BUSY;
    localparam logic [17:0] ILK = 18'h0_0001 << TSR_SB_INTERLOCK;
    localparam logic [17:0] EOT = 18'h0_0001 << TSR_SB_EOT_LP;
    logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic drop = 1'b0, ack, fstb, dstb, sval;
    logic [7:0] adr = 8'h00, op_len = 8'h08;
    logic [31:0] wdat = 32'h0000_0000, rdat, bdat, dword;
    logic [2:0] unit;
    logic [1:0] move;
    logic [8:0] fdata;
    logic [17:0] status;
    tsr_tape_in_s cond = '0, tape;
    int err_count = 0, comparisons = 0, ticks = 0, frames = 0;

    tsr_ctrl #(.LATE_DELAY_CYCLES(20)) dut (.clk_i(clk), .rst_i(rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(bdat), .wb_ack_o(ack),
        .tape_i(tape), .tape_unit_o(unit), .tape_move_o(move),
        .frame_data_o(fdata), .frame_stb_o(fstb), .data_word_o(dword),
        .data_stb_o(dstb), .status_o(status), .status_valid_o(sval));
    tsr_tape_model model (.clk_i(clk), .move_i(move), .frame_stb_i(fstb),
        .drop_i(drop), .op_len_i(op_len), .cond_i(cond), .tape_o(tape));

    initial
    begin
        forever #2 clk = ~clk;
    end

    always @(posedge clk)
    begin
        ticks <= ticks + 1;
        frames <= frames + int'(fstb);
        // Ceiling well above the longest expected run
        if (ticks == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // --------
    // Shared tasks
    // --------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            err_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Ack sampled mid-cycle, away from the edge that launches it
        do
            @(negedge clk);
        while (ack !== 1'b1);
        rdat = bdat;
        @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask : bus

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask : settle

    function automatic logic [8:0] fn(input logic [2:0] c, input logic n,
        input logic [2:0] u);
        return {1'b0, c, 1'b0, n, u};
    endfunction : fn

    task automatic run_fn(input logic [8:0] fw, input int late_at,
        input logic [17:0] exp);
        bus(1'b1, TSR_OFF_FUNC, {23'h00_0000, fw});
        if (late_at > 0)
        begin
            repeat (late_at) @(posedge clk);
            bus(1'b1, TSR_OFF_DATA, 32'h0000_00a5);
        end
        do
            bus(1'b0, TSR_OFF_CTRL, 32'h0000_0000);
        while (rdat[TSR_CB_DONE] !== 1'b1);
        bus(1'b0, TSR_OFF_STATUS, 32'h0000_0000);
        cmp(rdat, {14'h0000, exp});
    endtask : run_fn

    // --------
    // Scenarios
    // --------
    task automatic s_reset();
        bus(1'b0, TSR_OFF_CTRL, 32'h0000_0000);
        cmp(rdat, 32'h0000_0002);
        bus(1'b0, 8'h10, 32'h0000_0000);
        cmp(rdat, 32'h0000_0000);
        bus(1'b0, TSR_OFF_STATUS, 32'h0000_0000);
        cmp(rdat, 32'h0000_0000);
    endtask : s_reset

    task automatic s_invalid();
        run_fn(fn(3'h6, 1'b1, 3'h1) | 9'h010, 0, INV);
        cond.nine_track <= 8'hfa;
        settle();
        run_fn(fn(3'h6, 1'b1, 3'h2), 0, INV);
        run_fn(fn(3'h6, 1'b0, 3'h1), 0, INV);
        run_fn(fn(3'h4, 1'b1, 3'h0), 0, INV);
        cond.nine_track <= 8'hff;
        settle();
    endtask : s_invalid

    task automatic s_aux();
        bus(1'b1, TSR_OFF_CTRL, 32'h0000_0003);
        run_fn(fn(TSR_FN_WEOF, 1'b1, 3'h1), 0, INV);
        run_fn(fn(TSR_FN_WRITE, 1'b1, 3'h1), 0, INV);
        run_fn(fn(TSR_FN_SKIP, 1'b1, 3'h1), 0, INV);
        run_fn(fn(TSR_FN_REW_IL, 1'b1, 3'h1), 0, 18'h0_0000);
        bus(1'b1, TSR_OFF_CTRL, 32'h0000_0002);
    endtask : s_aux

    task automatic s_lock_busy();
        logic [2:0] u;
        cond.interlock[3] <= 1'b1;
        settle();
        run_fn(fn(3'h6, 1'b1, 3'h3), 0, ILK);
        run_fn(fn(3'h6, 1'b1, 3'h3) | 9'h010, 0, INV);
        cond.interlock[3] <= 1'b0;
        cond.rewinding[4] <= 1'b1;
        cond.other_cu[5] <= 1'b1;
        settle();
        u = unit;
        run_fn(fn(3'h7, 1'b1, 3'h4), 0, BSY);
        cmp({29'h0000_0000, unit}, {29'h0000_0000, u});
        run_fn(fn(3'h7, 1'b1, 3'h5), 0, BSY);
        cond.rewinding[4] <= 1'b0;
        cond.other_cu[5] <= 1'b0;
        settle();
        run_fn(fn(3'h7, 1'b1, 3'h4), 0, 18'h0_0000);
    endtask : s_lock_busy

    task automatic s_weof();
        int f0;
        op_len <= 8'd100;
        cond.hash <= 1'b1;
        cond.lat_par <= 1'b1;
        cond.eot[6] <= 1'b1;
        settle();
        f0 = frames;
        run_fn(fn(3'h0, 1'b1, 3'h6), 60, HSH | PAR | EOT | LAT);
        cmp(frames - f0, 32'h0000_0001);
        cmp({23'h00_0000, fdata}, 32'h0000_0013);
        cmp(dword, 32'h0000_00a5);
        op_len <= 8'h08;
        cond.hash <= 1'b0;
        cond.lat_par <= 1'b0;
        cond.eot[6] <= 1'b0;
        cond.lon_par <= 1'b1;
        settle();
        run_fn(fn(3'h0, 1'b1, 3'h6), 0, PAR);
        cond.lon_par <= 1'b0;
        cond.eot[6] <= 1'b1;
        settle();
        run_fn(fn(3'h1, 1'b1, 3'h6), 0, 18'h0_0000);
        run_fn(fn(3'h0, 1'b1, 3'h6), 0, EOT);
        cond.eot[6] <= 1'b0;
        cond.hash <= 1'b1;
        settle();
        run_fn(fn(3'h0, 1'b1, 3'h6), 0, HSH);
        cond.hash <= 1'b0;
    endtask : s_weof

    task automatic s_power();
        drop <= 1'b1;
        run_fn(fn(3'h6, 1'b1, 3'h1), 0, BSY | EOT);
        drop <= 1'b0;
        op_len <= 8'd60;
        cond.load_point[1] <= 1'b1;
        settle();
        run_fn(fn(3'h1, 1'b1, 3'h1), 0, BSY | EOT);
    endtask : s_power

    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict

    initial
    begin
        cond.nine_track = 8'hff;
        cond.powered = 8'hff;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        s_reset();
        s_invalid();
        s_aux();
        s_lock_busy();
        s_weof();
        s_power();
        give_verdict();
    end
endmodule : tb_tape_status_error_reporting
